// ===== include/chip_reset_defines.vh
// Constants for the chip reset source combiner.
// Assumes a single 125 MHz system clock and no register bus.
//
// Operation
// - Hold system reset while the power-on detector says supply not ready.
// - Every power-on reset sets the power-on flag, status bit 0.
// - Writing one clears the power-on flag; writing zero leaves it.
// - Low-voltage reset enabled by control bit 7; detector ignored for 200us.
// - Supply-low persisting past the selected de-glitch time resets the chip.
// - Stay in low-voltage reset until supply-high persists past de-glitch time.
// - After reset low-voltage reset is enabled with de-glitch filter off.
// - Processor reset acts as chip reset but keeps the boot-select bit.
`ifndef CHIP_RESET_DEFINES_VH
`define CHIP_RESET_DEFINES_VH

// Clock rate
`define CLK_MHZ 125

// Field positions
`define POWER_ON_FLAG_BIT 0
`define LOW_VOLT_ENABLE_BIT 7
`define LOW_VOLT_DEGLITCH_MSB 14
`define LOW_VOLT_DEGLITCH_LSB 12
`define BOOT_SELECT_BIT 1
`define SYSTEM_RESET_REQUEST_BIT 2

// Reset values
`define LOW_VOLT_ENABLE_RST 1'b1
`define LOW_VOLT_DEGLITCH_RST 3'h0
`define POWER_ON_FLAG_RST 1'b1
`define BOOT_SELECT_RST 1'b0

// Timing
`define LOW_VOLT_SETTLE_US 200
// 200 us at 125 MHz, sized to the 15-bit settle counter
`define LOW_VOLT_SETTLE_CYCLES 15'h61a8
`define PROC_RESET_CYCLES 8'h10

// De-glitch lengths in clock cycles for select codes 1 to 7
`define DEGLITCH_SEL1 9'h004
`define DEGLITCH_SEL2 9'h008
`define DEGLITCH_SEL3 9'h010
`define DEGLITCH_SEL4 9'h020
`define DEGLITCH_SEL5 9'h040
`define DEGLITCH_SEL6 9'h080
`define DEGLITCH_SEL7 9'h100

`endif

// ===== src/chip_reset_sources.v
// Chip reset source combiner: power-on, low-voltage and processor reset.
// Assumes analogue comparator levels arrive asynchronously and software
// writes arrive as one-cycle strobes on the system clock.
`include "chip_reset_defines.vh"

module chip_reset_sources #(
  parameter [14:0] LOW_VOLT_SETTLE = `LOW_VOLT_SETTLE_CYCLES
)
(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Analogue comparators
  input wire supply_ready,
  input wire supply_below_threshold,
  // Status write strobe
  input wire status_write,
  input wire power_on_flag_wdata,
  // Brown-out control write strobe
  input wire brownout_ctrl_write,
  input wire low_volt_reset_enable_wdata,
  input wire [2:0] low_volt_deglitch_select_wdata,
  // Processor reset request strobe
  input wire system_reset_request,
  // Boot select
  input wire config_boot_select,
  input wire boot_select_write,
  input wire boot_select_wdata,
  // Reset and status outputs
  output wire system_reset_n,
  output wire power_on_flag,
  output wire low_volt_reset_enable,
  output wire [2:0] low_volt_deglitch_select,
  output wire low_volt_active,
  output wire low_volt_reset,
  output wire proc_reset_active,
  output wire boot_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg ready_meta_reg;
  reg ready_sync_reg;
  reg low_meta_reg;
  reg low_sync_reg;
  reg power_on_flag_reg;
  reg enable_reg;
  reg [2:0] deglitch_reg;
  reg [14:0] settle_reg;
  reg [14:0] settle_next;
  reg active_reg;
  reg lvr_reg;
  reg lvr_next;
  reg [8:0] glitch_cnt_reg;
  reg [8:0] glitch_cnt_next;
  reg [8:0] glitch_limit;
  reg [7:0] proc_cnt_reg;
  reg boot_select_reg;
  reg sys_rst_n_reg;
  wire chip_reset;
  wire any_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      ready_meta_reg <= 1'b0;
      ready_sync_reg <= 1'b0;
      low_meta_reg <= 1'b0;
      low_sync_reg <= 1'b0;
    end
    else
    begin
      ready_meta_reg <= supply_ready;
      ready_sync_reg <= ready_meta_reg;
      low_meta_reg <= supply_below_threshold;
      low_sync_reg <= low_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on flag, set wins over the software clear
  always @(posedge clk)
  begin
    if (!nrst)
      power_on_flag_reg <= `POWER_ON_FLAG_RST;
    else if (!ready_sync_reg)
      power_on_flag_reg <= 1'b1;
    else if (status_write && power_on_flag_wdata)
      power_on_flag_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out control bits
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      enable_reg <= `LOW_VOLT_ENABLE_RST;
      deglitch_reg <= `LOW_VOLT_DEGLITCH_RST;
    end
    else if (brownout_ctrl_write)
    begin
      enable_reg <= low_volt_reset_enable_wdata;
      deglitch_reg <= low_volt_deglitch_select_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settling delay after the detector is enabled
  always @*
  begin
    settle_next = settle_reg;
    if (!enable_reg)
      settle_next = 15'h0000;
    else if (settle_reg != LOW_VOLT_SETTLE)
      settle_next = settle_reg + 15'h0001;
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      settle_reg <= 15'h0000;
      active_reg <= 1'b0;
    end
    else
    begin
      settle_reg <= settle_next;
      active_reg <= enable_reg && (settle_next == LOW_VOLT_SETTLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // De-glitch length lookup
  always @*
  begin
    case (deglitch_reg)
      3'h1: glitch_limit = `DEGLITCH_SEL1;
      3'h2: glitch_limit = `DEGLITCH_SEL2;
      3'h3: glitch_limit = `DEGLITCH_SEL3;
      3'h4: glitch_limit = `DEGLITCH_SEL4;
      3'h5: glitch_limit = `DEGLITCH_SEL5;
      3'h6: glitch_limit = `DEGLITCH_SEL6;
      3'h7: glitch_limit = `DEGLITCH_SEL7;
      default: glitch_limit = 9'h000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-voltage reset state with two-way de-glitch filter
  always @*
  begin
    lvr_next = lvr_reg;
    glitch_cnt_next = 9'h000;
    if (!active_reg || !enable_reg)
      lvr_next = 1'b0;
    else if (deglitch_reg == 3'h0)
      lvr_next = low_sync_reg;
    else if (low_sync_reg != lvr_reg)
    begin
      if (glitch_cnt_reg == glitch_limit)
        lvr_next = low_sync_reg;
      else
        glitch_cnt_next = glitch_cnt_reg + 9'h001;
    end
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      lvr_reg <= 1'b0;
      glitch_cnt_reg <= 9'h000;
    end
    else
    begin
      lvr_reg <= lvr_next;
      glitch_cnt_reg <= glitch_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor-requested reset stretched to a fixed length
  always @(posedge clk)
  begin
    if (!nrst)
      proc_cnt_reg <= 8'h00;
    else if (system_reset_request)
      proc_cnt_reg <= `PROC_RESET_CYCLES;
    else if (proc_cnt_reg != 8'h00)
      proc_cnt_reg <= proc_cnt_reg - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot select: reloaded by chip reset only, kept by processor reset
  always @(posedge clk)
  begin
    if (!nrst)
      boot_select_reg <= `BOOT_SELECT_RST;
    else if (chip_reset)
      boot_select_reg <= config_boot_select;
    else if (boot_select_write)
      boot_select_reg <= boot_select_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset combine and clocked release
  assign chip_reset = !ready_sync_reg || lvr_reg;
  assign any_reset = chip_reset || (proc_cnt_reg != 8'h00);

  always @(posedge clk)
  begin
    if (!nrst)
      sys_rst_n_reg <= 1'b0;
    else
      sys_rst_n_reg <= !any_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign system_reset_n = sys_rst_n_reg;
  assign power_on_flag = power_on_flag_reg;
  assign low_volt_reset_enable = enable_reg;
  assign low_volt_deglitch_select = deglitch_reg;
  assign low_volt_active = active_reg;
  assign low_volt_reset = lvr_reg;
  assign proc_reset_active = (proc_cnt_reg != 8'h00);
  assign boot_select = boot_select_reg;

endmodule // chip_reset_sources

// ===== test/chip_reset_sources_asserts.sv
// Checker bound to the chip reset combiner ports.
// Assumes synchronous active-low nrst and two-flop comparator sync.
module chip_reset_sources_asserts (
  // Inputs
  input logic clk,
  input logic nrst,
  input logic supply_ready,
  input logic supply_below_threshold,
  input logic system_reset_request,
  input logic boot_select_write,
  // Outputs
  input logic system_reset_n,
  input logic power_on_flag,
  input logic low_volt_reset_enable,
  input logic [2:0] low_volt_deglitch_select,
  input logic low_volt_active,
  input logic low_volt_reset,
  input logic proc_reset_active,
  input logic boot_select
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic [4:0] run_reg;
  // Cycles since the last processor reset request, stops at 17
  always @(posedge clk)
    if (!nrst || system_reset_request)
      run_reg <= {4'h0, nrst};
    else if (run_reg != 5'h0 && run_reg != 5'h11)
      run_reg <= run_reg + 5'h1;
  ////////////////////////////////////////
  a_por_hold: assert property (!supply_ready [*3] |=> !system_reset_n)
    else $error("reset released early");
  a_por_flag: assert property (!supply_ready [*3] |=> power_on_flag)
    else $error("flag not set");
  a_proc_start: assert property (
    system_reset_request |=> proc_reset_active ##1 !system_reset_n) else $error("no cpu reset");
  a_proc_len: assert property (
    run_reg != 5'h0 |-> proc_reset_active == (run_reg < 5'h11)) else $error("bad stretch");
  a_proc_boot: assert property (
    supply_ready [*3] ##0 (proc_reset_active && !boot_select_write && !low_volt_reset)
    |=> $stable(boot_select)) else $error("boot select moved");
  a_lv_off: assert property (
    !low_volt_reset_enable [*2] |-> !low_volt_reset && !low_volt_active) else $error("lv on");
  a_lv_direct: assert property (
    (low_volt_active && low_volt_deglitch_select == 3'h0 && supply_below_threshold) [*3]
    |=> low_volt_reset) else $error("lv late");
  a_lv_filter: assert property (
    $rose(low_volt_reset) && low_volt_deglitch_select == 3'h1
    |-> $past(supply_below_threshold, 7)) else $error("lv early");
  // Main scenarios reached
  c_proc: cover property ($rose(proc_reset_active));
  c_lvr: cover property ($rose(low_volt_reset));
  c_clear: cover property ($fell(power_on_flag));
endmodule // chip_reset_sources_asserts

// ===== test/supply_model.sv
// Far side: supply comparators and the software reset request.
// Assumes cmd bits: 2 supply ready, 1 below threshold, 0 request.
module supply_model (
  // Clock and command
  input logic clk,
  input logic [2:0] cmd,
  // Comparator levels and request strobe
  output logic supply_ready,
  output logic supply_below_threshold,
  output logic system_reset_request
);
  timeunit 1ns;
  timeprecision 100ps;
  // Levels follow the command a cycle late; request follows bit 0 the same way, for as long as bit 0 is held
  // Outputs are unknown only before the first edge, while nrst is still held
  always @(posedge clk)
    {supply_ready, supply_below_threshold, system_reset_request} <= #1 cmd;
endmodule // supply_model

// ===== test/chip_reset_sources_tb.sv
// Self-checking bench for the chip reset combiner.
// Assumes supply_model relays cmd; inputs move 1 ns after the edge.
bind chip_reset_sources chip_reset_sources_asserts u_chip_reset_sources_asserts (.*);
module chip_reset_sources_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, nrst = 1'h0, config_boot_select = 1'h0;
  logic status_write = 1'h0, power_on_flag_wdata = 1'h0, boot_select_write = 1'h0;
  logic brownout_ctrl_write = 1'h0, low_volt_reset_enable_wdata = 1'h0;
  logic boot_select_wdata = 1'h0;
  logic [2:0] cmd = 3'h4, low_volt_deglitch_select_wdata = 3'h0;
  wire supply_ready, supply_below_threshold, system_reset_request, system_reset_n;
  wire power_on_flag, low_volt_reset_enable, low_volt_active, low_volt_reset;
  wire proc_reset_active, boot_select;
  wire [2:0] low_volt_deglitch_select;
  int bad_count = 0, n_compared = 0;
  chip_reset_sources #(.LOW_VOLT_SETTLE(15'h14)) u_chip_reset_sources (.*);
  supply_model u_supply_model (.*);
  always #4 clk = ~clk;
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [2:0] e, input logic [2:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
      bad_count++;
    end
  endtask
  task automatic rn(input logic e);
    chk("system_reset_n", {2'h0, e}, {2'h0, system_reset_n});
  endtask
  // Strobe k: 4 status, 2 brown-out control, 1 boot select; d carries the data
  task automatic wr(input logic [2:0] k, input logic [3:0] d);
    {status_write, brownout_ctrl_write, boot_select_write} = k;
    {low_volt_reset_enable_wdata, low_volt_deglitch_select_wdata} = d;
    {power_on_flag_wdata, boot_select_wdata} = {d[0], d[0]};
    cyc(1);
    {status_write, brownout_ctrl_write, boot_select_write} = 3'h0;
    cyc(1);
  endtask
  task automatic end_sim;
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Reset, power-on, software, low-voltage and filter sequences
  initial
  begin
    cyc(20);
    chk("flag", 3'h1, {2'h0, power_on_flag});
    chk("enable", 3'h1, {2'h0, low_volt_reset_enable});
    chk("select", 3'h0, low_volt_deglitch_select);
    nrst = 1'h1;
    cyc(5);
    rn(1'h1);
    wr(3'h4, 4'h0);
    chk("flag", 3'h1, {2'h0, power_on_flag});
    wr(3'h4, 4'h1);
    chk("flag", 3'h0, {2'h0, power_on_flag});
    {cmd, config_boot_select} = 4'h1;
    cyc(6);
    chk("flag", 3'h1, {2'h0, power_on_flag});
    cyc(10);
    rn(1'h0);
    chk("boot", 3'h1, {2'h0, boot_select});
    cmd = 3'h4;
    cyc(8);
    rn(1'h1);
    wr(3'h1, 4'h0);
    cmd = 3'h5;
    cyc(1);
    cmd = 3'h4;
    cyc(17);
    rn(1'h0);
    chk("boot", 3'h0, {2'h0, boot_select});
    cyc(2);
    rn(1'h1);
    wr(3'h2, 4'h0);
    chk("active", 3'h0, {2'h0, low_volt_active});
    cmd = 3'h6;
    cyc(6);
    rn(1'h1);
    wr(3'h2, 4'h8);
    rn(1'h1);
    cyc(24);
    rn(1'h0);
    cmd = 3'h4;
    cyc(6);
    rn(1'h1);
    wr(3'h2, 4'h9);
    cmd = 3'h6;
    cyc(4);
    cmd = 3'h4;
    cyc(10);
    rn(1'h1);
    cmd = 3'h6;
    cyc(12);
    rn(1'h0);
    cmd = 3'h4;
    cyc(5);
    rn(1'h0);
    cyc(6);
    rn(1'h1);
    end_sim;
  end
  // Watchdog against a hang
  initial
  begin
    #4000;
    bad_count++;
    end_sim;
  end
endmodule // chip_reset_sources_tb
